//--- logic/ccu_defines.vh
// Register offsets, field positions and reset values of the compare/capture unit
`ifndef CCU_DEFINES_VH
`define CCU_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_SET_MASK 8'ha5
`define OFF_CLR_MASK 8'ha6
`define OFF_PORT5 8'hf8
`define OFF_CC_LO_BASE 8'hc0
`define OFF_COMSET_LO 8'hca
`define OFF_COMSET_HI 8'hcb
`define OFF_COMCLR_LO 8'hcc
`define OFF_COMCLR_HI 8'hcd
`define OFF_CM_LO_BASE 8'hd0
`define OFF_CC_EN 8'he0
`define OFF_CAP_CTL 8'he1
`define OFF_CC_MODE 8'he2
`define OFF_CC_LEVEL 8'he3
`define OFF_CM_EN 8'he4
`define OFF_CM_SEL 8'he5
`define OFF_CM_LEVEL 8'he6
`define OFF_RELOAD_CTL 8'he7
`define OFF_CM_FLAGS 8'he8
`define OFF_MISC_FLAGS 8'he9
`define OFF_CC_FLAGS 8'hea
`define OFF_CT_CTL 8'heb
`define OFF_CT_REL_LO 8'hec
`define OFF_CT_REL_HI 8'hed
`define OFF_CT_CNT_LO 8'hee
`define OFF_CT_CNT_HI 8'hef
`define OFF_CT_PRESC 8'hf0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RL_ENABLE 0
`define RL_EXT_MODE 1
`define RL_SET_EN 2
`define RL_CLR_EN 3
`define MISC_CTF 0
`define MISC_ICS 1
`define MISC_ICR 2
`define MISC_EXT 3
`define CAP_MODE_LSB 4
`define CT_RUN 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_PORT5 8'hff
`define CT_MAX_COUNT 16'hffff

`endif

//--- logic/compare_timer.v
// Sixteen-bit compare timer with eight-bit prescaler and reload
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"

module compare_timer (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire [7:0] presc,
	input wire [15:0] reload,
	output wire [15:0] count,
	output wire ovf
);

	reg half_r;
	reg [7:0] pcnt_r;
	reg [15:0] count_r;
	reg ovf_r;
	wire tick;

	// Half rate step keeps the count at most half the clock
	assign tick = run & half_r & (pcnt_r == presc);

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			half_r <= 1'b0;
			pcnt_r <= `RST_BYTE;
			count_r <= `RST_WORD;
			ovf_r <= 1'b0;
		end
		else
		begin
			ovf_r <= 1'b0;
			if (run)
				half_r <= ~half_r;
			if (run & half_r)
				pcnt_r <= (pcnt_r == presc) ? `RST_BYTE : pcnt_r + 8'h01;
			if (tick)
			begin
				if (count_r == `CT_MAX_COUNT)
				begin
					count_r <= reload;
					ovf_r <= 1'b1;
				end
				else
					count_r <= count_r + 16'h0001;
			end
		end
	end

	assign count = count_r;
	assign ovf = ovf_r;

endmodule // compare_timer
`default_nettype wire

//--- logic/compare_capture_reload_unit.v
// Compare, capture and timer reload logic of the compare/capture unit
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"

module compare_capture_reload_unit (
	input wire REF_CLK,
	input wire RESET_N,
	input wire [7:0] SFR_ADDR,
	input wire [7:0] SFR_WDATA,
	input wire SFR_WR,
	output wire [7:0] SFR_RDATA,
	input wire [15:0] T2_COUNT,
	input wire T2_OVF,
	output wire T2_RELOAD,
	output wire [15:0] T2_RELOAD_VALUE,
	input wire [3:0] CAPTURE_PIN_IN,
	input wire EXTERNAL_RELOAD_PIN,
	output wire [4:0] COMPARE_CAPTURE_PIN_OUT,
	output wire [7:0] ASSIGNABLE_COMPARE_OUT,
	output wire [7:0] CONCURRENT_COMPARE_OUT,
	output wire [4:0] CC_MATCH_IRQ,
	output wire ASSIGNABLE_MATCH_IRQ,
	output wire COMPARE_TIMER_OVERFLOW_IRQ,
	output wire SET_MATCH_IRQ,
	output wire CLEAR_MATCH_IRQ,
	output wire EXT_RELOAD_IRQ
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function addr_hit;
		input [7:0] a;
		input [7:0] base;
		input [3:0] k;
		begin
			addr_hit = (a == base + {3'b000, k, 1'b0});
		end
	endfunction

	function first_eq;
		input eq;
		input eq_prev;
		begin
			first_eq = eq & ~eq_prev;
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [15:0] cc_r [0:4];
	reg [15:0] cm_r [0:7];
	reg [15:0] cm_shadow_r [0:7];
	reg [15:0] comset_r;
	reg [15:0] comclr_r;
	reg [7:0] set_mask_r;
	reg [7:0] clr_mask_r;
	reg [7:0] port5_data_reg_r;
	reg [7:0] port5_nxt;
	reg [4:0] cc_en_r;
	reg [7:0] cap_ctl_r;
	reg [4:0] cc_mode_r;
	reg [4:0] cc_level_r;
	reg [7:0] cm_en_r;
	reg [7:0] cm_sel_r;
	reg [7:0] cm_level_r;
	reg [3:0] reload_ctl_r;
	reg [7:0] assignable_match_flags_r;
	reg [3:0] misc_flags_r;
	reg [4:0] cc_flags_r;
	reg [7:0] ct_ctl_r;
	reg [7:0] ct_presc_r;
	reg [15:0] ct_rel_r;
	reg [4:0] cc_out_r;
	reg [7:0] cm_out_r;
	reg [4:0] cc_eq_r;
	reg [7:0] cm_eq_r;
	reg set_eq_r;
	reg clr_eq_r;
	reg [3:0] cap_s1_r;
	reg [3:0] cap_s2_r;
	reg [3:0] cap_s3_r;
	reg [2:0] ext_sync_r;
	reg t2_reload_r;
	reg [15:0] t2_reload_value_r;
	reg [7:0] rdata_r;
	reg [7:0] rd_nxt;
	reg [4:0] cc_eq;
	reg [7:0] cm_eq;
	integer i;
	integer eq_idx;
	integer rd_idx;

	wire [15:0] ct_count;
	wire ct_ovf;
	wire [3:0] cap_rise;
	wire ext_fall;
	wire [4:0] cc_hit;
	wire [7:0] cm_hit;
	wire set_hit;
	wire clr_hit;
	wire reload_now;

	// ----------------------------------------------------------------
	// Compare timer
	// ----------------------------------------------------------------
	compare_timer u_compare_timer (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.run(ct_ctl_r[`CT_RUN]),
		.presc(ct_presc_r),
		.reload(ct_rel_r),
		.count(ct_count),
		.ovf(ct_ovf)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			cap_s1_r <= 4'h0;
			cap_s2_r <= 4'h0;
			cap_s3_r <= 4'h0;
			ext_sync_r <= 3'h7;
		end
		else
		begin
			cap_s1_r <= CAPTURE_PIN_IN;
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
			ext_sync_r <= {ext_sync_r[1:0], EXTERNAL_RELOAD_PIN};
		end
	end

	assign cap_rise = cap_s2_r & ~cap_s3_r;
	assign ext_fall = ext_sync_r[2] & ~ext_sync_r[1];

	// ----------------------------------------------------------------
	// Equality and match detection
	// ----------------------------------------------------------------
	always @*
	begin
		for (eq_idx = 0; eq_idx < 5; eq_idx = eq_idx + 1)
			cc_eq[eq_idx] = (cc_r[eq_idx] == T2_COUNT);
		for (eq_idx = 0; eq_idx < 8; eq_idx = eq_idx + 1)
			cm_eq[eq_idx] = cm_sel_r[eq_idx] ? (cm_shadow_r[eq_idx] == ct_count)
				: (cm_r[eq_idx] == T2_COUNT);
	end

	// Capture channels never compare
	assign cc_hit = first_eq(1'b1, 1'b0) ? (cc_eq & ~cc_eq_r & cc_en_r
		& ~{1'b0, cap_ctl_r[3:0]}) : 5'h00;
	assign cm_hit = cm_eq & ~cm_eq_r & cm_en_r;
	assign set_hit = reload_ctl_r[`RL_SET_EN] & first_eq(comset_r == T2_COUNT, set_eq_r);
	assign clr_hit = reload_ctl_r[`RL_CLR_EN] & first_eq(comclr_r == T2_COUNT, clr_eq_r);
	assign reload_now = reload_ctl_r[`RL_ENABLE]
		& (reload_ctl_r[`RL_EXT_MODE] ? ext_fall : T2_OVF);

	// ----------------------------------------------------------------
	// Port 5 concurrent compare
	// ----------------------------------------------------------------
	always @*
	begin
		port5_nxt = port5_data_reg_r;
		if (SFR_WR && SFR_ADDR == `OFF_PORT5)
			port5_nxt = SFR_WDATA;
		if (set_hit)
			port5_nxt = port5_nxt | set_mask_r;
		if (clr_hit)
			port5_nxt = port5_nxt & ~clr_mask_r;
	end

	// ----------------------------------------------------------------
	// Registers, capture and outputs
	// ----------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (!RESET_N)
		begin
			for (i = 0; i < 5; i = i + 1)
				cc_r[i] <= `RST_WORD;
			for (i = 0; i < 8; i = i + 1)
			begin
				cm_r[i] <= `RST_WORD;
				cm_shadow_r[i] <= `RST_WORD;
			end
			comset_r <= `RST_WORD;
			comclr_r <= `RST_WORD;
			set_mask_r <= `RST_BYTE;
			clr_mask_r <= `RST_BYTE;
			port5_data_reg_r <= `RST_PORT5;
			cc_en_r <= 5'h00;
			cap_ctl_r <= `RST_BYTE;
			cc_mode_r <= 5'h00;
			cc_level_r <= 5'h00;
			cm_en_r <= `RST_BYTE;
			cm_sel_r <= `RST_BYTE;
			cm_level_r <= `RST_BYTE;
			reload_ctl_r <= 4'h0;
			assignable_match_flags_r <= `RST_BYTE;
			misc_flags_r <= 4'h0;
			cc_flags_r <= 5'h00;
			ct_ctl_r <= `RST_BYTE;
			ct_presc_r <= `RST_BYTE;
			ct_rel_r <= `RST_WORD;
			cc_out_r <= 5'h00;
			cm_out_r <= `RST_BYTE;
			cc_eq_r <= 5'h00;
			cm_eq_r <= `RST_BYTE;
			set_eq_r <= 1'b0;
			clr_eq_r <= 1'b0;
			t2_reload_r <= 1'b0;
			t2_reload_value_r <= `RST_WORD;
			rdata_r <= `RST_BYTE;
		end
		else
		begin
			// Byte writes from the CPU
			for (i = 0; i < 5; i = i + 1)
			begin
				if (SFR_WR && addr_hit(SFR_ADDR, `OFF_CC_LO_BASE, i[3:0]))
					cc_r[i][7:0] <= SFR_WDATA;
				if (SFR_WR && addr_hit(SFR_ADDR, `OFF_CC_LO_BASE + 8'h01, i[3:0]))
					cc_r[i][15:8] <= SFR_WDATA;
			end
			// Capture overrides the stored value
			for (i = 0; i < 4; i = i + 1)
			begin
				if (cap_ctl_r[i] && !cap_ctl_r[`CAP_MODE_LSB + i] && cap_rise[i])
					cc_r[i] <= T2_COUNT;
				if (cap_ctl_r[i] && cap_ctl_r[`CAP_MODE_LSB + i] && SFR_WR
					&& addr_hit(SFR_ADDR, `OFF_CC_LO_BASE, i[3:0]))
					cc_r[i] <= T2_COUNT;
			end
			for (i = 0; i < 8; i = i + 1)
			begin
				if (SFR_WR && addr_hit(SFR_ADDR, `OFF_CM_LO_BASE, i[3:0]))
					cm_r[i][7:0] <= SFR_WDATA;
				if (SFR_WR && addr_hit(SFR_ADDR, `OFF_CM_LO_BASE + 8'h01, i[3:0]))
					cm_r[i][15:8] <= SFR_WDATA;
				if (ct_ovf)
					cm_shadow_r[i] <= cm_r[i];
				// Compare timer side runs mode 0, general timer side mode 1
				if (cm_sel_r[i])
				begin
					if (cm_hit[i])
						cm_out_r[i] <= 1'b1;
					else if (ct_ovf)
						cm_out_r[i] <= 1'b0;
				end
				else if (cm_hit[i])
					cm_out_r[i] <= cm_level_r[i];
			end
			for (i = 0; i < 5; i = i + 1)
			begin
				if (cc_mode_r[i])
				begin
					if (cc_hit[i])
						cc_out_r[i] <= cc_level_r[i];
				end
				else if (cc_hit[i])
					cc_out_r[i] <= 1'b1;
				else if (T2_OVF)
					cc_out_r[i] <= 1'b0;
			end
			if (SFR_WR)
			begin
				case (SFR_ADDR)
					`OFF_COMSET_LO: comset_r[7:0] <= SFR_WDATA;
					`OFF_COMSET_HI: comset_r[15:8] <= SFR_WDATA;
					`OFF_COMCLR_LO: comclr_r[7:0] <= SFR_WDATA;
					`OFF_COMCLR_HI: comclr_r[15:8] <= SFR_WDATA;
					`OFF_SET_MASK: set_mask_r <= SFR_WDATA;
					`OFF_CLR_MASK: clr_mask_r <= SFR_WDATA;
					`OFF_CC_EN: cc_en_r <= SFR_WDATA[4:0];
					`OFF_CAP_CTL: cap_ctl_r <= SFR_WDATA;
					`OFF_CC_MODE: cc_mode_r <= SFR_WDATA[4:0];
					`OFF_CC_LEVEL: cc_level_r <= SFR_WDATA[4:0];
					`OFF_CM_EN: cm_en_r <= SFR_WDATA;
					`OFF_CM_SEL: cm_sel_r <= SFR_WDATA;
					`OFF_CM_LEVEL: cm_level_r <= SFR_WDATA;
					`OFF_RELOAD_CTL: reload_ctl_r <= SFR_WDATA[3:0];
					`OFF_CT_CTL: ct_ctl_r <= SFR_WDATA;
					`OFF_CT_PRESC: ct_presc_r <= SFR_WDATA;
					`OFF_CT_REL_LO: ct_rel_r[7:0] <= SFR_WDATA;
					`OFF_CT_REL_HI: ct_rel_r[15:8] <= SFR_WDATA;
					default: ;
				endcase
			end
			port5_data_reg_r <= port5_nxt;
			// Request flags: a hardware set wins over a software write
			assignable_match_flags_r <= ((SFR_WR && SFR_ADDR == `OFF_CM_FLAGS) ? SFR_WDATA
				: assignable_match_flags_r) | (cm_hit & ~cm_sel_r);
			misc_flags_r <= ((SFR_WR && SFR_ADDR == `OFF_MISC_FLAGS) ? SFR_WDATA[3:0]
				: misc_flags_r) | {reload_ctl_r[`RL_EXT_MODE] & ext_fall,
				clr_hit, set_hit, ct_ovf};
			cc_flags_r <= ((SFR_WR && SFR_ADDR == `OFF_CC_FLAGS) ? SFR_WDATA[4:0]
				: cc_flags_r) | cc_hit;
			cc_eq_r <= cc_eq;
			cm_eq_r <= cm_eq;
			set_eq_r <= (comset_r == T2_COUNT);
			clr_eq_r <= (comclr_r == T2_COUNT);
			t2_reload_r <= reload_now;
			t2_reload_value_r <= {cc_r[0][15:8], cc_r[0][7:0]};
			rdata_r <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	always @*
	begin
		rd_nxt = `RST_BYTE;
		case (SFR_ADDR)
			`OFF_COMSET_LO: rd_nxt = comset_r[7:0];
			`OFF_COMSET_HI: rd_nxt = comset_r[15:8];
			`OFF_COMCLR_LO: rd_nxt = comclr_r[7:0];
			`OFF_COMCLR_HI: rd_nxt = comclr_r[15:8];
			`OFF_SET_MASK: rd_nxt = set_mask_r;
			`OFF_CLR_MASK: rd_nxt = clr_mask_r;
			`OFF_PORT5: rd_nxt = port5_data_reg_r;
			`OFF_CC_EN: rd_nxt = {3'b000, cc_en_r};
			`OFF_CAP_CTL: rd_nxt = cap_ctl_r;
			`OFF_CC_MODE: rd_nxt = {3'b000, cc_mode_r};
			`OFF_CC_LEVEL: rd_nxt = {3'b000, cc_level_r};
			`OFF_CM_EN: rd_nxt = cm_en_r;
			`OFF_CM_SEL: rd_nxt = cm_sel_r;
			`OFF_CM_LEVEL: rd_nxt = cm_level_r;
			`OFF_RELOAD_CTL: rd_nxt = {4'h0, reload_ctl_r};
			`OFF_CM_FLAGS: rd_nxt = assignable_match_flags_r;
			`OFF_MISC_FLAGS: rd_nxt = {4'h0, misc_flags_r};
			`OFF_CC_FLAGS: rd_nxt = {3'b000, cc_flags_r};
			`OFF_CT_CTL: rd_nxt = ct_ctl_r;
			`OFF_CT_PRESC: rd_nxt = ct_presc_r;
			`OFF_CT_REL_LO: rd_nxt = ct_rel_r[7:0];
			`OFF_CT_REL_HI: rd_nxt = ct_rel_r[15:8];
			`OFF_CT_CNT_LO: rd_nxt = ct_count[7:0];
			`OFF_CT_CNT_HI: rd_nxt = ct_count[15:8];
			default: rd_nxt = `RST_BYTE;
		endcase
		for (rd_idx = 0; rd_idx < 5; rd_idx = rd_idx + 1)
		begin
			if (addr_hit(SFR_ADDR, `OFF_CC_LO_BASE, rd_idx[3:0]))
				rd_nxt = cc_r[rd_idx][7:0];
			if (addr_hit(SFR_ADDR, `OFF_CC_LO_BASE + 8'h01, rd_idx[3:0]))
				rd_nxt = cc_r[rd_idx][15:8];
		end
		for (rd_idx = 0; rd_idx < 8; rd_idx = rd_idx + 1)
		begin
			if (addr_hit(SFR_ADDR, `OFF_CM_LO_BASE, rd_idx[3:0]))
				rd_nxt = cm_r[rd_idx][7:0];
			if (addr_hit(SFR_ADDR, `OFF_CM_LO_BASE + 8'h01, rd_idx[3:0]))
				rd_nxt = cm_r[rd_idx][15:8];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign SFR_RDATA = rdata_r;
	assign T2_RELOAD = t2_reload_r;
	assign T2_RELOAD_VALUE = t2_reload_value_r;
	assign COMPARE_CAPTURE_PIN_OUT = cc_out_r;
	assign ASSIGNABLE_COMPARE_OUT = cm_out_r;
	assign CONCURRENT_COMPARE_OUT = port5_data_reg_r;
	assign CC_MATCH_IRQ = cc_flags_r;
	assign ASSIGNABLE_MATCH_IRQ = |assignable_match_flags_r;
	assign COMPARE_TIMER_OVERFLOW_IRQ = misc_flags_r[`MISC_CTF];
	assign SET_MATCH_IRQ = misc_flags_r[`MISC_ICS];
	assign CLEAR_MATCH_IRQ = misc_flags_r[`MISC_ICR];
	assign EXT_RELOAD_IRQ = misc_flags_r[`MISC_EXT];

endmodule // compare_capture_reload_unit
`default_nettype wire

//--- verif/general_timer_model.sv
// Behavioural model of the general-purpose timer beside the unit
`timescale 1ns/10ps
`default_nettype none

module general_timer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic preset,
	input wire logic [15:0] preset_val,
	input wire logic reload,
	input wire logic [15:0] reload_val,
	output wire logic [15:0] count,
	output wire logic ovf
);
logic [15:0] count_r;
logic ovf_r;
assign count = count_r;
assign ovf = ovf_r;

always @(posedge clk)
begin
	if (!rst_n)
	begin
		count_r <= 16'h0000;
		ovf_r <= 1'b0;
	end
	else
	begin
		ovf_r <= run && !preset && !reload && count_r == 16'hffff;
		if (preset)
			count_r <= preset_val;
		else if (reload)
			count_r <= reload_val;
		else if (run)
			count_r <= count_r + 16'h0001;
	end
end
endmodule // general_timer_model
`default_nettype wire

//--- verif/compare_capture_reload_unit_checker.sv
// Port assertions of the compare, capture and reload unit
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"

module compare_capture_reload_unit_checker (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic [15:0] T2_COUNT,
	input wire logic T2_OVF,
	input wire logic T2_RELOAD,
	input wire logic [15:0] T2_RELOAD_VALUE,
	input wire logic EXTERNAL_RELOAD_PIN,
	input wire logic [7:0] CONCURRENT_COMPARE_OUT,
	input wire logic SET_MATCH_IRQ,
	input wire logic CLEAR_MATCH_IRQ,
	input wire logic EXT_RELOAD_IRQ
);
// ----------------------------------------
// Register mirrors
// ----------------------------------------
logic [7:0] rl_r, smsk_r, cmsk_r;
logic [15:0] rel_r, sv_r, cv_r;
logic seq_r, ceq_r;
wire logic s_eq = T2_COUNT == sv_r;
wire logic c_eq = T2_COUNT == cv_r;
wire logic s_hit = rl_r[`RL_SET_EN] && s_eq && !seq_r;
wire logic c_hit = rl_r[`RL_CLR_EN] && c_eq && !ceq_r;

always @(posedge REF_CLK)
begin
	if (!RESET_N)
		{rl_r, smsk_r, cmsk_r, rel_r, sv_r, cv_r, seq_r, ceq_r} <= '0;
	else
	begin
		seq_r <= s_eq;
		ceq_r <= c_eq;
		if (SFR_WR)
			case (SFR_ADDR)
				`OFF_RELOAD_CTL: rl_r <= SFR_WDATA;
				`OFF_SET_MASK: smsk_r <= SFR_WDATA;
				`OFF_CLR_MASK: cmsk_r <= SFR_WDATA;
				`OFF_CC_LO_BASE: rel_r[7:0] <= SFR_WDATA;
				`OFF_CC_LO_BASE + 8'h01: rel_r[15:8] <= SFR_WDATA;
				`OFF_COMSET_LO: sv_r[7:0] <= SFR_WDATA;
				`OFF_COMSET_HI: sv_r[15:8] <= SFR_WDATA;
				`OFF_COMCLR_LO: cv_r[7:0] <= SFR_WDATA;
				`OFF_COMCLR_HI: cv_r[15:8] <= SFR_WDATA;
				default: ;
			endcase
	end
end

// ----------------------------------------
// Properties
// ----------------------------------------
default clocking dc @(posedge REF_CLK);
endclocking
default disable iff (!RESET_N);

property p_rel_ovf;
	T2_OVF && rl_r[1:0] == 2'b01 |=> T2_RELOAD;
endproperty
a_rel_ovf: assert property (p_rel_ovf) else $error("no reload after overflow");
property p_rel_val;
	T2_RELOAD && $stable(rel_r) |-> T2_RELOAD_VALUE == rel_r;
endproperty
a_rel_val: assert property (p_rel_val) else $error("reload value wrong");
property p_rel_gate;
	T2_RELOAD |-> $past(rl_r[`RL_ENABLE]);
endproperty
a_rel_gate: assert property (p_rel_gate) else $error("reload while disabled");
property p_ext_rel;
	$fell(EXTERNAL_RELOAD_PIN) && rl_r[1:0] == 2'b11 |-> ##[1:6] T2_RELOAD;
endproperty
a_ext_rel: assert property (p_ext_rel) else $error("no reload on pin fall");
property p_ext_irq;
	$fell(EXTERNAL_RELOAD_PIN) && rl_r[`RL_EXT_MODE] |-> ##[1:6] EXT_RELOAD_IRQ;
endproperty
a_ext_irq: assert property (p_ext_irq) else $error("no request on pin fall");
property p_p5_rst;
	$rose(RESET_N) |-> CONCURRENT_COMPARE_OUT == 8'hff && !T2_RELOAD;
endproperty
a_p5_rst: assert property (p_p5_rst) else $error("port 5 reset value wrong");
property p_p5_wr;
	SFR_WR && SFR_ADDR == `OFF_PORT5 && !s_hit && !c_hit
		|=> CONCURRENT_COMPARE_OUT == $past(SFR_WDATA);
endproperty
a_p5_wr: assert property (p_p5_wr) else $error("port 5 write lost");
property p_set;
	s_hit && !c_hit |=> ((CONCURRENT_COMPARE_OUT & $past(smsk_r)) == $past(smsk_r))
		&& SET_MATCH_IRQ;
endproperty
a_set: assert property (p_set) else $error("set match not applied");
property p_clr;
	c_hit |=> ((CONCURRENT_COMPARE_OUT & $past(cmsk_r)) == 8'h00) && CLEAR_MATCH_IRQ;
endproperty
a_clr: assert property (p_clr) else $error("clear match not applied");
endmodule // compare_capture_reload_unit_checker

bind compare_capture_reload_unit compare_capture_reload_unit_checker chk (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR),
	.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .T2_COUNT(T2_COUNT), .T2_OVF(T2_OVF),
	.T2_RELOAD(T2_RELOAD), .T2_RELOAD_VALUE(T2_RELOAD_VALUE),
	.EXTERNAL_RELOAD_PIN(EXTERNAL_RELOAD_PIN),
	.CONCURRENT_COMPARE_OUT(CONCURRENT_COMPARE_OUT), .SET_MATCH_IRQ(SET_MATCH_IRQ),
	.CLEAR_MATCH_IRQ(CLEAR_MATCH_IRQ), .EXT_RELOAD_IRQ(EXT_RELOAD_IRQ)
);
`default_nettype wire

//--- verif/tb_compare_capture_reload_unit.sv
// Self-checking testbench of the compare, capture and reload unit
`timescale 1ns/10ps
`default_nettype none
`include "ccu_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module tb_compare_capture_reload_unit;
logic REF_CLK = 1'b0;
logic RESET_N = 1'b0;
logic [7:0] SFR_ADDR = 8'h00;
logic [7:0] SFR_WDATA = 8'h00;
logic SFR_WR = 1'b0;
logic [3:0] CAPTURE_PIN_IN = 4'h0;
logic EXTERNAL_RELOAD_PIN = 1'b1;
logic run = 1'b0;
logic pre = 1'b0;
logic [15:0] pre_v = 16'h0000;
wire logic [7:0] SFR_RDATA, CONCURRENT_COMPARE_OUT, ASSIGNABLE_COMPARE_OUT;
wire logic [15:0] T2_COUNT, T2_RELOAD_VALUE;
wire logic [4:0] COMPARE_CAPTURE_PIN_OUT, CC_MATCH_IRQ;
wire logic T2_OVF, T2_RELOAD, ASSIGNABLE_MATCH_IRQ, SET_MATCH_IRQ, CLEAR_MATCH_IRQ;
wire logic EXT_RELOAD_IRQ, COMPARE_TIMER_OVERFLOW_IRQ;
int check_count = 0;
int miscompares = 0;

always #50 REF_CLK = ~REF_CLK;

compare_capture_reload_unit dut (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
	.SFR_WR(SFR_WR), .SFR_RDATA(SFR_RDATA), .T2_COUNT(T2_COUNT), .T2_OVF(T2_OVF),
	.T2_RELOAD(T2_RELOAD), .T2_RELOAD_VALUE(T2_RELOAD_VALUE),
	.CAPTURE_PIN_IN(CAPTURE_PIN_IN), .EXTERNAL_RELOAD_PIN(EXTERNAL_RELOAD_PIN),
	.COMPARE_CAPTURE_PIN_OUT(COMPARE_CAPTURE_PIN_OUT),
	.ASSIGNABLE_COMPARE_OUT(ASSIGNABLE_COMPARE_OUT),
	.CONCURRENT_COMPARE_OUT(CONCURRENT_COMPARE_OUT), .CC_MATCH_IRQ(CC_MATCH_IRQ),
	.ASSIGNABLE_MATCH_IRQ(ASSIGNABLE_MATCH_IRQ),
	.COMPARE_TIMER_OVERFLOW_IRQ(COMPARE_TIMER_OVERFLOW_IRQ),
	.SET_MATCH_IRQ(SET_MATCH_IRQ), .CLEAR_MATCH_IRQ(CLEAR_MATCH_IRQ),
	.EXT_RELOAD_IRQ(EXT_RELOAD_IRQ)
);

general_timer_model tmr (
	.clk(REF_CLK), .rst_n(RESET_N), .run(run), .preset(pre), .preset_val(pre_v),
	.reload(T2_RELOAD), .reload_val(T2_RELOAD_VALUE), .count(T2_COUNT), .ovf(T2_OVF)
);

// ----------------------------------------
// Bus and timer tasks
// ----------------------------------------
task automatic tk(input int n);
	repeat (n) @(posedge REF_CLK);
	#1;
endtask

task automatic wr(input logic [7:0] a, input logic [7:0] d);
	SFR_ADDR = a;
	SFR_WDATA = d;
	SFR_WR = 1'b1;
	tk(1);
	SFR_WR = 1'b0;
	tk(1);
endtask

task automatic wr16(input logic [7:0] a, input logic [15:0] v);
	wr(a, v[7:0]);
	wr(a + 8'h01, v[15:8]);
endtask

task automatic rd(input logic [7:0] a, input logic [7:0] e);
	SFR_ADDR = a;
	tk(1);
	`CHK(SFR_RDATA, e)
endtask

task automatic setc(input logic [15:0] v, input logic r);
	run = r;
	pre_v = v;
	pre = 1'b1;
	tk(1);
	pre = 1'b0;
endtask

task automatic end_sim;
	$display("checks %0d mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask

// ----------------------------------------
// Test sequence
// ----------------------------------------
initial
begin
	tk(16);
	RESET_N = 1'b1;
	`CHK(CONCURRENT_COMPARE_OUT, 8'hff)
	`CHK(COMPARE_CAPTURE_PIN_OUT, 5'h00)
	rd(8'h00, 8'h00);
	wr(`OFF_PORT5, 8'h5a);
	rd(`OFF_PORT5, 8'h5a);
	wr(`OFF_SET_MASK, 8'h0f);
	wr(`OFF_CLR_MASK, 8'h03);
	rd(`OFF_SET_MASK, 8'h0f);
	rd(`OFF_CLR_MASK, 8'h03);
	wr(`OFF_PORT5, 8'h00);
	wr16(`OFF_COMSET_LO, 16'h1000);
	wr16(`OFF_COMCLR_LO, 16'h1010);
	wr(`OFF_RELOAD_CTL, 8'h0c);
	setc(16'h0ff0, 1'b1);
	tk(20);
	`CHK(CONCURRENT_COMPARE_OUT, 8'h0f)
	`CHK({SET_MATCH_IRQ, CLEAR_MATCH_IRQ}, 2'b10)
	tk(16);
	`CHK(CONCURRENT_COMPARE_OUT, 8'h0c)
	`CHK({SET_MATCH_IRQ, CLEAR_MATCH_IRQ}, 2'b11)
	rd(`OFF_PORT5, 8'h0c);
	wr(`OFF_MISC_FLAGS, 8'h00);
	`CHK({SET_MATCH_IRQ, CLEAR_MATCH_IRQ}, 2'b00)
	wr(`OFF_RELOAD_CTL, 8'h00);
	wr16(`OFF_CC_LO_BASE + 8'h02, 16'h2000);
	wr16(`OFF_CC_LO_BASE + 8'h04, 16'h2000);
	wr16(`OFF_CM_LO_BASE, 16'h2000);
	wr(`OFF_CC_MODE, 8'h04);
	wr(`OFF_CC_LEVEL, 8'h04);
	wr(`OFF_CM_EN, 8'h01);
	wr(`OFF_CM_LEVEL, 8'h01);
	wr(`OFF_CC_EN, 8'h06);
	setc(16'h1ff0, 1'b1);
	tk(20);
	`CHK(COMPARE_CAPTURE_PIN_OUT, 5'h06)
	`CHK(CC_MATCH_IRQ, 5'h06)
	`CHK({ASSIGNABLE_COMPARE_OUT[0], ASSIGNABLE_MATCH_IRQ}, 2'b11)
	setc(16'hfff8, 1'b1);
	tk(12);
	`CHK(COMPARE_CAPTURE_PIN_OUT, 5'h04)
	`CHK(ASSIGNABLE_COMPARE_OUT[0], 1'b1)
	wr(`OFF_CC_FLAGS, 8'h00);
	setc(16'h2000, 1'b0);
	tk(4);
	wr(`OFF_CC_FLAGS, 8'h00);
	tk(4);
	`CHK(CC_MATCH_IRQ, 5'h00)
	wr(`OFF_CC_EN, 8'h00);
	wr(`OFF_CAP_CTL, 8'h88);
	setc(16'h1234, 1'b0);
	wr(`OFF_CC_LO_BASE + 8'h06, 8'h00);
	rd(`OFF_CC_LO_BASE + 8'h06, 8'h34);
	rd(`OFF_CC_LO_BASE + 8'h07, 8'h12);
	wr(`OFF_CAP_CTL, 8'h02);
	setc(16'h4321, 1'b0);
	CAPTURE_PIN_IN = 4'h2;
	tk(5);
	CAPTURE_PIN_IN = 4'h0;
	rd(`OFF_CC_LO_BASE + 8'h02, 8'h21);
	rd(`OFF_CC_LO_BASE + 8'h03, 8'h43);
	wr16(`OFF_CC_LO_BASE, 16'habcd);
	wr(`OFF_RELOAD_CTL, 8'h01);
	setc(16'hfffc, 1'b1);
	tk(10);
	`CHK(T2_RELOAD_VALUE, 16'habcd)
	`CHK(T2_COUNT, 16'habd1)
	wr(`OFF_RELOAD_CTL, 8'h03);
	setc(16'h0100, 1'b0);
	EXTERNAL_RELOAD_PIN = 1'b0;
	tk(6);
	`CHK(T2_COUNT, 16'habcd)
	`CHK(EXT_RELOAD_IRQ, 1'b1)
	EXTERNAL_RELOAD_PIN = 1'b1;
	wr(`OFF_CM_FLAGS, 8'h00);
	wr16(`OFF_CM_LO_BASE + 8'h02, 16'h0003);
	wr(`OFF_CM_EN, 8'h02);
	wr(`OFF_CM_SEL, 8'h02);
	`CHK(ASSIGNABLE_COMPARE_OUT, 8'h03)
	`CHK(ASSIGNABLE_MATCH_IRQ, 1'b0)
	wr(`OFF_CT_CTL, 8'h01);
	tk(9);
	rd(`OFF_CT_CNT_LO, 8'h05);
	wr(`OFF_MISC_FLAGS, 8'h01);
	`CHK(COMPARE_TIMER_OVERFLOW_IRQ, 1'b1)
	end_sim;
end

initial
begin
	tk(5000);
	miscompares++;
	end_sim;
end
endmodule // tb_compare_capture_reload_unit
`default_nettype wire
